// ==== logic/bif_pkg.sv ====
// bif_pkg: constants and types of the feeder controller.
// assumes one 200 MHz clock and a plain register port.
//
// Functional notes
// - pick one sheet, convey it into printer
// - both cassettes share identical control logic
// - lift at power-on, install, stack lowered
// - drive lifter until surface sensor sees paper
// - while printing, relift when surface drops
// - lift timeout without surface means motor failure
// - report cassette media size, A4-R or Letter-R
// - report cassette presence from open switches
// - size and presence frozen during sleep
// - no-pick 1: cassette feed sensor timeout
// - no-pick 3: merged feed sensor timeout
// - no-pick 4: manual tray sensor timeout
// - residual paper at off, door close, wake
// - side door open during feed jams
package bif_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_HZ       = 200_000_000;      // core clock rate
  localparam int LIFT_TO_MS   = 1000;             // lift must reach surface in this time
  localparam int PICK_TO_MS   = 300;              // solenoid on to cassette feed sensor
  localparam int MERGE_TO_MS  = 300;              // cassette feed sensor to merged feed sensor
  localparam int TRAY_TO_MS   = 300;              // merged feed sensor to manual tray sensor
  localparam int LIFT_TO_CYC  = LIFT_TO_MS * (CLK_HZ / 1000);
  localparam int PICK_TO_CYC  = PICK_TO_MS * (CLK_HZ / 1000);
  localparam int MERGE_TO_CYC = MERGE_TO_MS * (CLK_HZ / 1000);
  localparam int TRAY_TO_CYC  = TRAY_TO_MS * (CLK_HZ / 1000);

  // ------------------------------------------------------------
  // register map (word index on the register port)
  // ------------------------------------------------------------
  localparam int          ADDR_W      = 4;
  localparam int          DATA_W      = 32;
  localparam logic [3:0]  REG_CTRL    = 4'h0;  // rw: power save, printing
  localparam logic [3:0]  REG_CMD     = 4'h1;  // w: pick right, pick left, power-off check
  localparam logic [3:0]  REG_STATUS  = 4'h2;  // r: presence, size, motors, feed state
  localparam logic [3:0]  REG_JAM     = 4'h3;  // r: sticky jam bits, cleared by the read
  localparam logic [3:0]  REG_MASK    = 4'h4;  // rw: interrupt mask over the jam bits
  localparam logic [3:0]  REG_LIFT_TO = 4'h5;  // rw: lift timeout in cycles
  localparam logic [3:0]  REG_PICK_TO = 4'h6;  // rw: pick timeout in cycles
  localparam logic [3:0]  REG_MRG_TO  = 4'h7;  // rw: merge timeout in cycles
  localparam logic [3:0]  REG_TRAY_TO = 4'h8;  // rw: tray timeout in cycles

  // control and command bit positions
  localparam int CTRL_SAVE   = 0;  // power-save (sleep) level
  localparam int CTRL_PRINT  = 1;  // print operation in progress
  localparam int CMD_PICK_R  = 0;
  localparam int CMD_PICK_L  = 1;
  localparam int CMD_OFFCHK  = 2;  // power-off residual check

  // jam bit positions, one distinct code each
  localparam int JAM_W       = 8;
  localparam int JAM_LIFT_R  = 0;
  localparam int JAM_LIFT_L  = 1;
  localparam int JAM_NP1_R   = 2;
  localparam int JAM_NP1_L   = 3;
  localparam int JAM_NP3     = 4;
  localparam int JAM_NP4     = 5;
  localparam int JAM_RESID   = 6;
  localparam int JAM_DOOR    = 7;

  // reset values
  localparam logic [1:0]       CTRL_RST = 2'h0;
  localparam logic [JAM_W-1:0] MASK_RST = 8'h00;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic sideDoorOpen;   // side door switch, high = open
    logic rightOpen;      // right cassette open switch, high = out
    logic leftOpen;       // left cassette open switch, high = out
    logic rightUpper;     // right stack surface upper sensor
    logic rightLower;     // right stack surface lower sensor
    logic leftUpper;      // left stack surface upper sensor
    logic leftLower;      // left stack surface lower sensor
    logic rightSize;      // right size sensor, high = A4-R
    logic leftSize;       // left size sensor, high = A4-R
    logic mergedFeed;     // merged feed sensor, high = paper
    logic rightFeed;      // right feed sensor
    logic leftFeed;       // left feed sensor
    logic trayFeed;       // manual feed tray sensor in the printer
  } bif_sens_t;

  typedef enum logic [1:0] {
    LIFT_IDLE = 2'b00,
    LIFT_RUN  = 2'b01,
    LIFT_FAIL = 2'b10
  } bif_lift_t;

  typedef enum logic [1:0] {
    FEED_IDLE  = 2'b00,
    FEED_PICK  = 2'b01,
    FEED_MERGE = 2'b10,
    FEED_TRAY  = 2'b11
  } bif_feed_t;

endpackage : bif_pkg

// ==== logic/bif_timer.sv ====
// bif_timer: one-shot down counter, pulses at run-out.
// assumes start and clear on the same clock.
`timescale 1ns/1ps
module bif_timer
  import bif_pkg::*;
(
  input  wire logic        clock,    // core clock
  input  wire logic        nrst,     // async reset, active low
  input  wire logic        start,    // load limit and run
  input  wire logic        clear,    // stop without expiring
  input  wire logic [31:0] limit,    // cycles until expiry
  output logic             expired   // one-cycle pulse at run-out
);

  logic [31:0] count;    // remaining cycles
  logic        running;  // counting

  // ------------------------------------------------------------
  // countdown; a limit of zero behaves as one cycle
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count   <= 32'h0;
      running <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (start) begin                       // restart at the trigger
        count   <= limit;
        running <= 1'b1;
      end else if (clear) begin
        running <= 1'b0;
      end else if (running) begin
        if (count <= 32'h1) begin
          expired <= 1'b1;
          running <= 1'b0;
        end else begin
          count <= count - 32'h1;
        end
      end
    end
  end

endmodule : bif_timer

// ==== logic/bif_lift_ctrl.sv ====
// bif_lift_ctrl: lifter control, one instance per cassette.
// assumes synchronised sensors and a limit from the register file.
`timescale 1ns/1ps
module bif_lift_ctrl
  import bif_pkg::*;
(
  input  wire logic        clock,     // core clock
  input  wire logic        nrst,      // async reset, active low
  input  wire logic        present,   // cassette installed
  input  wire logic        upperSurf, // surface at pickup position
  input  wire logic        lowerSurf, // surface not yet dropped
  input  wire logic        printing,  // print operation active
  input  wire logic [31:0] limit,     // lift timeout in cycles
  output logic             motor,     // lifter motor drive
  output logic             fail       // one-cycle failure pulse
);

  bif_lift_t state;         // lift state
  logic      powerOnPend;   // power-on lift still owed
  logic      presentQ;      // presence one cycle ago
  logic      expired;       // timer run-out

  wire installEdge = present && !presentQ;
  wire lowered     = printing && !lowerSurf;
  wire startLift   = present && !upperSurf && (powerOnPend || installEdge || lowered);
  wire startTimer  = (state == LIFT_IDLE) && startLift;

  bif_timer u_timer (
    .clock   (clock),
    .nrst    (nrst),
    .start   (startTimer),
    .clear   (state != LIFT_RUN),
    .limit   (limit),
    .expired (expired)
  );

  // ------------------------------------------------------------
  // lift sequencing
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state       <= LIFT_IDLE;
      powerOnPend <= 1'b1;
      presentQ    <= 1'b0;
      motor       <= 1'b0;
      fail        <= 1'b0;
    end else begin
      presentQ    <= present;
      powerOnPend <= 1'b0;   // owed only in the first cycle; install covers late cassettes
      fail        <= 1'b0;
      unique case (state)
        LIFT_IDLE: begin
          if (startTimer) begin
            state <= LIFT_RUN;
            motor <= 1'b1;
          end
        end
        LIFT_RUN: begin
          if (!present || upperSurf) begin   // stop at surface
            state <= LIFT_IDLE;
            motor <= 1'b0;
          end else if (expired) begin
            state <= LIFT_FAIL;
            motor <= 1'b0;
            fail  <= 1'b1;
          end
        end
        LIFT_FAIL: begin
          // held off until the cassette is pulled; reinsertion retries
          if (!present) begin
            state <= LIFT_IDLE;
          end
        end
        default: begin
          state <= LIFT_IDLE;
          motor <= 1'b0;
        end
      endcase
    end
  end

endmodule : bif_lift_ctrl

// ==== logic/bif_feeder_ctrl.sv ====
// bif_feeder_ctrl: feeder top: lift, detection, pick and jams.
// assumes async sensor pins and the engine controller on the register port.
`timescale 1ns/1ps
module bif_feeder_ctrl
  import bif_pkg::*;
#(
  parameter logic [31:0] LIFT_LIMIT  = LIFT_TO_CYC,   // lift timeout reset value
  parameter logic [31:0] PICK_LIMIT  = PICK_TO_CYC,   // pick timeout reset value
  parameter logic [31:0] MERGE_LIMIT = MERGE_TO_CYC,  // merge timeout reset value
  parameter logic [31:0] TRAY_LIMIT  = TRAY_TO_CYC    // tray timeout reset value
)
(
  input  wire logic              clock,              // 200 MHz core clock
  input  wire logic              nrst,               // async reset, active low
  input  wire bif_sens_t         sensors,            // raw sensor and switch pins
  input  wire logic [ADDR_W-1:0] addr,               // register index
  input  wire logic [DATA_W-1:0] wdata,              // write data
  input  wire logic              wr,                 // write strobe
  input  wire logic              rd,                 // read strobe
  output logic      [DATA_W-1:0] rdata,              // read data, cycle after rd
  output logic                   irq,                // level interrupt
  output logic                   rightLifterMotor,   // right lifter motor drive
  output logic                   leftLifterMotor,    // left lifter motor drive
  output logic                   rightPickupMotor,   // right pickup motor drive
  output logic                   leftPickupMotor,    // left pickup motor drive
  output logic                   rightPickupSolenoid,// right pickup solenoid
  output logic                   leftPickupSolenoid  // left pickup solenoid
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  bif_sens_t syncA;   // first stage, read only by syncB
  bif_sens_t syncB;   // second stage, safe to use
  bif_sens_t sensQ;   // one cycle later, for edges

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      syncA <= '0;
      syncB <= '0;
      sensQ <= '0;
    end else begin
      syncA <= sensors;
      syncB <= syncA;
      sensQ <= syncB;
    end
  end

  // ------------------------------------------------------------
  // register file state
  // ------------------------------------------------------------
  logic [1:0]       ctrl;        // save and printing levels
  logic [JAM_W-1:0] jam;         // sticky jam codes
  logic [JAM_W-1:0] mask;        // interrupt mask
  logic [31:0]      liftLimit;   // lift timeout
  logic [31:0]      pickLimit;   // pick timeout
  logic [31:0]      mergeLimit;  // merge timeout
  logic [31:0]      trayLimit;   // tray timeout
  logic [1:0]       presentRep;  // reported presence, right/left
  logic [1:0]       sizeRep;     // reported size, 1 = A4-R
  logic             saveQ;       // power-save one cycle ago

  // decode of the register port
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] r);
    hit = (a == r);
  endfunction : hit

  wire sleeping  = ctrl[CTRL_SAVE];
  wire printing  = ctrl[CTRL_PRINT];
  wire wrCmd     = wr && hit(addr, REG_CMD);
  wire pickRight = wrCmd && wdata[CMD_PICK_R];
  wire pickLeft  = wrCmd && wdata[CMD_PICK_L] && !wdata[CMD_PICK_R];  // right wins a tie
  wire offCheck  = wrCmd && wdata[CMD_OFFCHK];
  wire rdJam     = rd && hit(addr, REG_JAM);

  // ------------------------------------------------------------
  // lift control, one per cassette
  // ------------------------------------------------------------
  logic [1:0] liftFail;   // failure pulses, right/left
  logic [1:0] liftMotor;  // lifter motors, right/left
  logic [1:0] present;    // live presence
  logic [1:0] upperS;     // upper sensors
  logic [1:0] lowerS;     // lower sensors

  assign present = {!syncB.leftOpen, !syncB.rightOpen};
  assign upperS  = {syncB.leftUpper, syncB.rightUpper};
  assign lowerS  = {syncB.leftLower, syncB.rightLower};

  // identical logic for both cassettes
  for (genvar c = 0; c < 2; c++) begin : g_lift
    bif_lift_ctrl u_lift (
      .clock     (clock),
      .nrst      (nrst),
      .present   (present[c]),
      .upperSurf (upperS[c]),
      .lowerSurf (lowerS[c]),
      .printing  (printing),
      .limit     (liftLimit),
      .motor     (liftMotor[c]),
      .fail      (liftFail[c])
    );
  end

  assign rightLifterMotor = liftMotor[0];
  assign leftLifterMotor  = liftMotor[1];

  // ------------------------------------------------------------
  // feed sequence
  // ------------------------------------------------------------
  bif_feed_t feed;       // feed stage
  logic      sel;        // 0 = right cassette, 1 = left
  logic      expired;    // stage timer run-out

  wire feedBusy   = (feed != FEED_IDLE);
  wire doorJam    = feedBusy && syncB.sideDoorOpen;
  wire selFeed    = sel ? syncB.leftFeed : syncB.rightFeed;
  wire startPick  = !feedBusy && ((pickRight && present[0]) || (pickLeft && present[1]));
  wire toMerge    = (feed == FEED_PICK) && selFeed && !doorJam;
  wire toTray     = (feed == FEED_MERGE) && syncB.mergedFeed && !doorJam;
  wire stageStart = startPick || toMerge || toTray;
  wire np1        = (feed == FEED_PICK) && expired && !selFeed;
  wire np3        = (feed == FEED_MERGE) && expired && !syncB.mergedFeed;
  wire np4        = (feed == FEED_TRAY) && expired && !syncB.trayFeed;

  // each stage loads its own programmable limit
  wire [31:0] stageLimit = startPick ? pickLimit : (toMerge ? mergeLimit : trayLimit);

  bif_timer u_feed_timer (
    .clock   (clock),
    .nrst    (nrst),
    .start   (stageStart),
    .clear   (!feedBusy),
    .limit   (stageLimit),
    .expired (expired)
  );

  // stage walk: solenoid, cassette sensor, merged sensor, printer tray
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      feed <= FEED_IDLE;
      sel  <= 1'b0;
    end else begin
      unique case (feed)
        FEED_IDLE: begin
          if (startPick) begin
            feed <= FEED_PICK;
            sel  <= !pickRight;
          end
        end
        FEED_PICK: begin
          if (doorJam || np1) begin
            feed <= FEED_IDLE;
          end else if (toMerge) begin
            feed <= FEED_MERGE;
          end
        end
        FEED_MERGE: begin
          if (doorJam || np3) begin
            feed <= FEED_IDLE;
          end else if (toTray) begin
            feed <= FEED_TRAY;
          end
        end
        FEED_TRAY: begin
          // sheet handed to the printer ends the feed
          if (doorJam || np4 || syncB.trayFeed) begin
            feed <= FEED_IDLE;
          end
        end
      endcase
    end
  end

  // pickup drives from flops; solenoid only while waiting for the edge
  wire [1:0] pickSel = sel ? 2'b10 : 2'b01;
  wire [1:0] nextSol = (startPick ? {!pickRight, pickRight} : 2'b00) |
                       (((feed == FEED_PICK) && !toMerge && !np1 && !doorJam) ? pickSel : 2'b00);
  wire [1:0] nextMot = (startPick ? {!pickRight, pickRight} : 2'b00) |
                       ((feedBusy && !doorJam && !np1 && !np3 && !np4 &&
                         !((feed == FEED_TRAY) && syncB.trayFeed)) ? pickSel : 2'b00);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rightPickupSolenoid <= 1'b0;
      leftPickupSolenoid  <= 1'b0;
      rightPickupMotor    <= 1'b0;
      leftPickupMotor     <= 1'b0;
    end else begin
      rightPickupSolenoid <= nextSol[0];
      leftPickupSolenoid  <= nextSol[1];
      rightPickupMotor    <= nextMot[0];
      leftPickupMotor     <= nextMot[1];
    end
  end

  // ------------------------------------------------------------
  // residual paper check events
  // ------------------------------------------------------------
  wire doorClosed = sensQ.sideDoorOpen && !syncB.sideDoorOpen;
  wire wake       = saveQ && !sleeping;
  wire paperLeft  = syncB.mergedFeed || syncB.rightFeed || syncB.leftFeed;
  wire residual   = (offCheck || doorClosed || wake) && paperLeft;

  // ------------------------------------------------------------
  // jam codes: set wins over the acknowledging read
  // ------------------------------------------------------------
  logic [JAM_W-1:0] jamSet;   // events this cycle
  always_comb begin
    jamSet             = '0;
    jamSet[JAM_LIFT_R] = liftFail[0];
    jamSet[JAM_LIFT_L] = liftFail[1];
    jamSet[JAM_NP1_R]  = np1 && !sel;
    jamSet[JAM_NP1_L]  = np1 && sel;
    jamSet[JAM_NP3]    = np3;
    jamSet[JAM_NP4]    = np4;
    jamSet[JAM_RESID]  = residual;
    jamSet[JAM_DOOR]   = doorJam;
  end

  wire [JAM_W-1:0] next_jam = (rdJam ? '0 : jam) | jamSet;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      jam <= '0;
      irq <= 1'b0;
    end else begin
      jam <= next_jam;
      irq <= |(next_jam & mask);
    end
  end

  // ------------------------------------------------------------
  // size and presence reporting, frozen in sleep
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      presentRep <= 2'b00;
      sizeRep    <= 2'b00;
      saveQ      <= 1'b0;
    end else begin
      saveQ <= sleeping;
      if (!sleeping) begin
        presentRep <= present;
        sizeRep    <= {syncB.leftSize, syncB.rightSize};
      end
    end
  end

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl       <= CTRL_RST;
      mask       <= MASK_RST;
      liftLimit  <= LIFT_LIMIT;
      pickLimit  <= PICK_LIMIT;
      mergeLimit <= MERGE_LIMIT;
      trayLimit  <= TRAY_LIMIT;
    end else if (wr) begin
      if (hit(addr, REG_CTRL))    ctrl       <= wdata[1:0];
      if (hit(addr, REG_MASK))    mask       <= wdata[JAM_W-1:0];
      if (hit(addr, REG_LIFT_TO)) liftLimit  <= wdata;
      if (hit(addr, REG_PICK_TO)) pickLimit  <= wdata;
      if (hit(addr, REG_MRG_TO))  mergeLimit <= wdata;
      if (hit(addr, REG_TRAY_TO)) trayLimit  <= wdata;
    end
  end

  // ------------------------------------------------------------
  // register reads; unmapped indices read zero
  // ------------------------------------------------------------
  wire [DATA_W-1:0] statusWord = {23'h0, feed, feedBusy, liftMotor, sizeRep, presentRep};
  wire [DATA_W-1:0] rdMux =
      hit(addr, REG_CTRL)    ? {30'h0, ctrl}        :
      hit(addr, REG_STATUS)  ? statusWord           :
      hit(addr, REG_JAM)     ? {24'h0, jam}         :
      hit(addr, REG_MASK)    ? {24'h0, mask}        :
      hit(addr, REG_LIFT_TO) ? liftLimit            :
      hit(addr, REG_PICK_TO) ? pickLimit            :
      hit(addr, REG_MRG_TO)  ? mergeLimit           :
      hit(addr, REG_TRAY_TO) ? trayLimit            : 32'h0;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata <= 32'h0;
    end else begin
      rdata <= rd ? rdMux : 32'h0;   // valid only the cycle after rd
    end
  end

endmodule : bif_feeder_ctrl

// ==== test/bif_feeder_checker.sv ====
// bif_feeder_checker: port-level assertions for the feeder controller.
// assumes one clock domain and the top's ports only.
`timescale 1ns/1ps
module bif_feeder_checker
  import bif_pkg::*;
(
  input wire logic              clock,               // clock
  input wire logic              nrst,                // reset
  input wire bif_sens_t         sensors,             // pins
  input wire logic [ADDR_W-1:0] addr,                // index
  input wire logic [DATA_W-1:0] wdata,               // data
  input wire logic              wr,                  // write
  input wire logic              rd,                  // read
  input wire logic [DATA_W-1:0] rdata,               // read data
  input wire logic              rightLifterMotor,    // lift r
  input wire logic              leftLifterMotor,     // lift l
  input wire logic              rightPickupMotor,    // pick r
  input wire logic              leftPickupMotor,     // pick l
  input wire logic              rightPickupSolenoid  // sol r
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  a_rdata_quiet: assert property (!rd |=> rdata == '0) else $error("rdata late");
  a_pick_taken: assert property ((!sensors.rightOpen)[*3] ##0 (wr && addr == REG_CMD && wdata[CMD_PICK_R]
    && !rightPickupMotor && !leftPickupMotor) |=> rightPickupSolenoid && rightPickupMotor)
    else $error("no pick");
  a_lift_stop_r: assert property (sensors.rightUpper[*4] |=> !rightLifterMotor) else $error("lift r on");
  a_lift_stop_l: assert property (sensors.leftUpper[*4] |=> !leftLifterMotor) else $error("lift l on");
  a_sol_release: assert property ((sensors.rightFeed && !wr)[*4] |=> !rightPickupSolenoid)
    else $error("sol held");
  a_door_abort: assert property ((sensors.sideDoorOpen && !wr)[*6] |=> !rightPickupMotor && !leftPickupMotor)
    else $error("door feed");
  a_one_side: assert property (!(rightPickupMotor && leftPickupMotor)) else $error("two picks");
  a_sol_motor: assert property (rightPickupSolenoid |-> rightPickupMotor) else $error("sol alone");
endmodule : bif_feeder_checker
bind bif_feeder_ctrl bif_feeder_checker chk (.clock, .nrst, .sensors, .addr, .wdata, .wr, .rd, .rdata,
  .rightLifterMotor, .leftLifterMotor, .rightPickupMotor, .leftPickupMotor, .rightPickupSolenoid);

// ==== test/bif_paper_model.sv ====
// bif_paper_model: lifters and paper path seen by the sensors.
// assumes motor and solenoid levels from the controller.
`timescale 1ns/1ps
module bif_paper_model (
  input  wire logic       clock,     // clock
  input  wire logic       rLift,     // lifter r
  input  wire logic       lLift,     // lifter l
  input  wire logic       rSol,      // solenoid r
  input  wire logic       lSol,      // solenoid l
  input  wire logic       pick,      // a pickup motor runs
  input  wire logic       rOut,      // cassette r out
  input  wire logic       lOut,      // cassette l out
  input  wire logic [1:0] stall,     // stage never reached
  input  wire logic       liftStall, // lifter slips
  output logic            rUp,       // surface r
  output logic            lUp,       // surface l
  output logic            rFeed,     // feed r
  output logic            lFeed,     // feed l
  output logic            mFeed,     // merged feed
  output logic            tFeed      // tray feed
);
  logic [7:0] n = 8'h00;  // cycles of feed
  logic [3:0] rl = 4'h0;  // lift travel r
  logic [3:0] ll = 4'h0;  // lift travel l
  logic       side = 1'b0; // 1 = left sheet
  // lift travel saturates at the top
  always @(posedge clock) begin
    n <= pick ? n + 8'h01 : 8'h00;
    if (lSol) side <= 1'b1;
    else if (rSol) side <= 1'b0;
    rl <= rOut ? 4'h0 : rl + {3'h0, rLift && !liftStall && rl < 4'h8};
    ll <= lOut ? 4'h0 : ll + {3'h0, lLift && !liftStall && ll < 4'h8};
  end
  assign rUp = rl == 4'h8;
  assign lUp = ll == 4'h8;
  // sheet moves only with the motor
  assign rFeed = pick && !side && n > 8'h06 && stall != 2'h1;
  assign lFeed = pick && side && n > 8'h06 && stall != 2'h1;
  assign mFeed = pick && n > 8'h0C && stall != 2'h2 && stall != 2'h1;
  assign tFeed = pick && n > 8'h12 && stall == 2'h0;
endmodule : bif_paper_model

// ==== test/tb_bif_feeder_ctrl.sv ====
// tb_bif_feeder_ctrl: self-checking feeder bench.
// assumes the paper model stands in for the mechanics.
`timescale 1ns/1ps
module tb_bif_feeder_ctrl
  import bif_pkg::*;
;
  `define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
  logic clock = 0, nrst = 0, wr = 0, rd = 0, door = 0, rOut = 0, lOut = 0, rSz = 0, hold = 0, liftStall = 0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [1:0] stall = 2'h0;
  logic irq, rLm, lLm, rPm, lPm, rSol, lSol, rUp, lUp, rF, lF, mF, tF;
  int errors = 0, total_checks = 0;
  bif_sens_t sens;
  assign sens = '{door, rOut, lOut, rUp, 1'b1, lUp, 1'b1, rSz, 1'b0, mF, rF, lF | hold, tF};
  always #2.5 clock = ~clock;
  bif_feeder_ctrl #(.LIFT_LIMIT(32'h28), .PICK_LIMIT(32'h1E), .MERGE_LIMIT(32'h1E), .TRAY_LIMIT(32'h1E)) dut (
    .clock, .nrst, .sensors(sens), .addr, .wdata, .wr, .rd, .rdata, .irq, .rightLifterMotor(rLm),
    .leftLifterMotor(lLm), .rightPickupMotor(rPm), .leftPickupMotor(lPm), .rightPickupSolenoid(rSol),
    .leftPickupSolenoid(lSol));
  bif_paper_model pm (.clock, .rLift(rLm), .lLift(lLm), .rSol, .lSol, .pick(rPm | lPm), .rOut, .lOut,
    .stall, .liftStall, .rUp, .lUp, .rFeed(rF), .lFeed(lF), .mFeed(mF), .tFeed(tF));
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
  endtask : cyc
  task automatic wreg(input logic [3:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    cyc(1);
    wr <= 1'b0;
    cyc(1);
  endtask : wreg
  // read data stand in the cycle after rd
  task automatic rreg(input logic [3:0] a);
    addr <= a;
    rd <= 1'b1;
    cyc(1);
    rd <= 1'b0;
    cyc(1);
    d = rdata;
  endtask : rreg
  task automatic jam(input logic [7:0] e);
    rreg(REG_JAM);
    `CHK("jam", e, d[7:0])
  endtask : jam
  task automatic idle();
    for (int i = 0; i < 300 && (rPm || lPm); i++) cyc(1);
    cyc(4);
  endtask : idle
  task automatic t_regs();
    rreg(REG_MASK);
    `CHK("mask", 32'h0, d)
    wreg(4'hF, 32'h5);
    rreg(4'hF);
    `CHK("unmapped", 32'h0, d)
    wreg(REG_PICK_TO, 32'h20);
    rreg(REG_PICK_TO);
    `CHK("pickTo", 32'h20, d)
    $display("regs done");
  endtask : t_regs
  task automatic t_lift();
    `CHK("powerOn", 2'h3, {rUp, lUp})
    rOut <= 1'b1;
    liftStall <= 1'b1;
    cyc(10);
    rOut <= 1'b0;
    cyc(8);
    `CHK("install", 1'b1, rLm)
    cyc(50);
    `CHK("failStop", 1'b0, rLm)
    `CHK("irqMasked", 1'b0, irq)
    jam(8'h01);
    jam(8'h00);
    liftStall <= 1'b0;
    rOut <= 1'b1;
    cyc(6);
    rOut <= 1'b0;
    cyc(30);
    `CHK("relift", 2'h2, {rUp, rLm})
    $display("lift done");
  endtask : t_lift
  task automatic t_feed();
    wreg(REG_CMD, 32'h1);
    `CHK("sol", 1'b1, rSol)
    idle();
    jam(8'h00);
    wreg(REG_MASK, 32'h3C);
    // stall each stage, left cassette
    for (int s = 1; s < 4; s++) begin
      stall <= s[1:0];
      wreg(REG_CMD, 32'h2);
      idle();
      `CHK("irq", 1'b1, irq)
      jam(8'h01 << (s + 2));
      `CHK("irqClr", 1'b0, irq)
    end
    stall <= 2'h0;
    $display("feed done");
  endtask : t_feed
  task automatic t_door();
    wreg(REG_CMD, 32'h1);
    door <= 1'b1;
    cyc(8);
    `CHK("doorStop", 1'b0, rPm)
    door <= 1'b0;
    cyc(4);
    jam(8'h80);
    $display("door done");
  endtask : t_door
  task automatic t_sleep();
    rSz <= 1'b1;
    cyc(4);
    rreg(REG_STATUS);
    `CHK("size", 4'h7, d[3:0])
    wreg(REG_CTRL, 32'h1);
    rOut <= 1'b1;
    rSz <= 1'b0;
    hold <= 1'b1;
    cyc(4);
    rreg(REG_STATUS);
    `CHK("frozen", 4'h7, d[3:0])
    wreg(REG_CTRL, 32'h0);
    cyc(4);
    rreg(REG_STATUS);
    `CHK("present", 4'h2, d[3:0])
    jam(8'h40);
    wreg(REG_CMD, 32'h4);
    jam(8'h40);
    hold <= 1'b0;
    rOut <= 1'b0;
    $display("sleep done");
  endtask : t_sleep
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  initial begin
    cyc(4);
    nrst <= 1'b1;
    cyc(60);
    t_regs();
    t_lift();
    t_feed();
    t_door();
    t_sleep();
    end_of_test();
  end
  // watchdog
  initial begin
    #20000;
    errors++;
    end_of_test();
  end
endmodule : tb_bif_feeder_ctrl
